// [bench/decoder_regfile.sv]
`timescale 1ns/10ps
`default_nettype none
module decoder_regfile (
	// Clock
	input wire logic clk_i,
	// Program side
	input wire logic [core_pkg::PC_W-1:0] pc_i,
	output logic [core_pkg::INSN_W-1:0] word_o,
	// Decode and register file side
	input wire logic [core_pkg::INSN_W-1:0] insn_i,
	input wire logic insn_valid_i,
	input wire core_pkg::dmem_wr_t wr_i,
	output core_pkg::exec_cmd_t cmd_o,
	output logic [core_pkg::DATA_W-1:0] rdata_o
);
	core_pkg::exec_cmd_t prog [0:1023];
	logic [7:0] mem [0:127];
	// Program word is its own address, so the fetch path is visible
	assign word_o = {4'h0, pc_i};
	// A word marked invalid (reset or branch bubble) decodes to no command
	always_comb
	begin
		cmd_o = prog[insn_i[9:0]];
		cmd_o.valid = cmd_o.valid && insn_valid_i;
	end
	// Write-first, so a read right after a write sees the new byte
	assign rdata_o = (wr_i.we && wr_i.addr == cmd_o.reg_addr) ? wr_i.data : mem[cmd_o.reg_addr];
	always @(posedge clk_i)
		if (wr_i.we)
			mem[wr_i.addr] <= wr_i.data;
endmodule // decoder_regfile
`default_nettype wire

// [bench/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
	typedef struct packed {
		logic [7:0] acc;
		core_pkg::flags_t fl;
		core_pkg::dmem_wr_t wr;
		logic nxt;
	} note_t;
	localparam int WORDS = 512;
	logic clk_i = 1'h0;
	logic rstn_i = 1'h0;
	logic [9:0] pma, last_addr;
	logic [13:0] pmd, insn;
	logic insn_valid, take;
	core_pkg::exec_cmd_t cmd;
	logic [7:0] rdata, acc;
	logic [6:0] raddr, last_raddr;
	core_pkg::dmem_wr_t wr;
	core_pkg::flags_t flags;
	note_t notes [$];
	note_t exp_n;
	int fails = 0;
	int n_compared = 0;
	integer seed = 49223;
	always #50 clk_i = ~clk_i;
	alu_datapath #(.PROG_WORDS(WORDS)) i_alu_datapath (.clk_i(clk_i), .rstn_i(rstn_i),
		.pmem_addr_o(pma), .pmem_data_i(pmd), .insn_o(insn), .insn_valid_o(insn_valid),
		.cmd_i(cmd), .dmem_raddr_o(raddr), .dmem_rdata_i(rdata), .dmem_wr_o(wr), .acc_o(acc),
		.flags_o(flags));
	decoder_regfile i_decoder_regfile (.clk_i(clk_i), .pc_i(pma), .word_o(pmd), .insn_i(insn),
		.insn_valid_i(insn_valid), .wr_i(wr), .cmd_o(cmd), .rdata_o(rdata));
	task automatic check(input string what, input logic [27:0] e, input logic [27:0] g);
		n_compared++;
		if (g !== e)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Watcher: one note per executed command
	always @(posedge clk_i)
	begin
		take = rstn_i && insn_valid === 1'h1 && cmd.valid === 1'h1;
		last_addr = pma;
		last_raddr = cmd.reg_addr;
		#2;
		if (rstn_i)
			check("dmem_raddr_o", {21'h0, last_raddr}, {21'h0, raddr});
		if (rstn_i && insn_valid === 1'h1)
			check("insn_o", {18'h0, last_addr}, {14'h0, insn});
		if (take && notes.size() > 0)
		begin
			exp_n = notes.pop_front();
			check("result", exp_n, {acc, flags, wr.we ? wr : 16'h0, insn_valid});
		end
	end
	initial
	begin : main
		core_pkg::exec_cmd_t c, flush_cmd;
		logic [7:0] m [0:127];
		logic [7:0] a, b, x, y;
		logic [8:0] s;
		logic cf, ncf;
		core_pkg::flags_t f;
		note_t n;
		int p, r, w;
		a = 8'h00;
		f = '0;
		for (int i = 0; i < 1024; i++)
			i_decoder_regfile.prog[i] = '0;
		for (int i = 0; i < 128; i++)
		begin
			m[i] = 8'($random(seed));
			i_decoder_regfile.mem[i] = m[i];
		end
		flush_cmd = '0;
		flush_cmd.valid = 1'h1;
		flush_cmd.op = core_pkg::ALU_CLR;
		flush_cmd.one_operand = 1'h1;
		flush_cmd.to_acc = 1'h1;
		flush_cmd.upd_z = 1'h1;
		c = '0;
		c.valid = 1'h1;
		c.branch = 1'h1;
		c.target = 10'h100;
		i_decoder_regfile.prog[0] = c;
		i_decoder_regfile.prog[1] = flush_cmd;
		p = 10'h100;
		for (int i = 0; i < 27; i++)
		begin
			r = $random(seed);
			c = '0;
			c.valid = 1'h1;
			c.branch = i == 22;
			c.target = 10'h1FC;
			if (i != 22)
			begin
				c.op = core_pkg::alu_op_t'(i % 13);
				c.one_operand = c.op >= core_pkg::ALU_NOT;
				c.operand_is_acc = r[0];
				c.src = r[1] ? core_pkg::SRC_LIT : core_pkg::SRC_REG;
				c.literal = r[15:8];
				c.reg_addr = {3'h2, r[19:16]};
				c.to_acc = r[2];
				c.write_reg = !r[2];
				c.upd_c = r[3] && c.op inside {core_pkg::ALU_ADD, core_pkg::ALU_SUB, core_pkg::ALU_RLC, core_pkg::ALU_RRC};
				c.upd_nc = r[4] && c.op inside {core_pkg::ALU_ADD, core_pkg::ALU_SUB};
				c.upd_z = r[5] && !(c.op inside {core_pkg::ALU_RLC, core_pkg::ALU_RRC});
			end
			i_decoder_regfile.prog[p] = c;
			if (c.branch)
				i_decoder_regfile.prog[p + 1] = flush_cmd;
			p = c.branch ? 10'h1FC : p + 1;
		end
		// Reference run, wrapping at the top of program space
		p = 0;
		for (int k = 0; k < 100; k++)
		begin
			c = i_decoder_regfile.prog[p];
			x = c.operand_is_acc ? a : m[c.reg_addr];
			b = c.src == core_pkg::SRC_LIT ? c.literal : m[c.reg_addr];
			s = {1'h0, a} + b;
			cf = s[8];
			ncf = ({1'h0, a[3:0]} + b[3:0]) > 5'h0F;
			y = s[7:0];
			case (c.op)
				core_pkg::ALU_PASS_B: y = b;
				core_pkg::ALU_SUB:
				begin
					s = {1'h0, b} - a;
					y = s[7:0];
					cf = !s[8];
					ncf = b[3:0] >= a[3:0];
				end
				core_pkg::ALU_AND: y = a & b;
				core_pkg::ALU_OR: y = a | b;
				core_pkg::ALU_XOR: y = a ^ b;
				core_pkg::ALU_NOT: y = ~x;
				core_pkg::ALU_RLC: {cf, y} = {x, f.c};
				core_pkg::ALU_RRC: {y, cf} = {f.c, x};
				core_pkg::ALU_SWAP: y = {x[3:0], x[7:4]};
				core_pkg::ALU_INC: y = x + 8'h01;
				core_pkg::ALU_DEC: y = x - 8'h01;
				core_pkg::ALU_CLR: y = 8'h00;
				default: ;
			endcase
			n = '0;
			if (c.upd_c)
				f.c = cf;
			if (c.upd_nc)
				f.nc = ncf;
			if (c.upd_z)
				f.z = y == 8'h00;
			if (c.to_acc)
				a = y;
			if (c.write_reg)
			begin
				m[c.reg_addr] = y;
				n.wr = {1'h1, c.reg_addr, y};
			end
			n.acc = a;
			n.fl = f;
			n.nxt = !c.branch;
			notes.push_back(n);
			p = c.branch ? c.target : (p + 1) % WORDS;
		end
		repeat (5) @(posedge clk_i);
		#1 rstn_i = 1'h1;
		for (w = 0; w < 2000 && notes.size() > 0; w++)
			@(posedge clk_i);
		if (notes.size() > 0)
			fails++;
		@(posedge clk_i);
		#5 $display("test alu_branch_sequence done");
		test_done();
	end
endmodule // testbench
`default_nettype wire

// [core/alu8.sv]
`timescale 1ns/10ps
`default_nettype none
module alu8 #(
	parameter int W = 8
) (
	// Operation and operands
	input wire core_pkg::alu_op_t op_i,
	input wire logic [W-1:0] a_i,
	input wire logic [W-1:0] b_i,
	input wire logic c_i,
	// Result
	output logic [W-1:0] y_o,
	output core_pkg::flags_t flags_o
);
	logic [W:0] full;
	logic [4:0] low;
	always_comb
	begin
		full = {1'b0, b_i};
		low = {1'b0, b_i[3:0]};
		flags_o.c = c_i;
		unique case (op_i)
			core_pkg::ALU_ADD:
			begin
				full = {1'b0, a_i} + {1'b0, b_i};
				low = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]};
				flags_o.c = full[W];
			end
			core_pkg::ALU_SUB:
			begin
				full = {1'b0, b_i} + {1'b0, ~a_i} + {{W{1'b0}}, 1'b1};
				low = {1'b0, b_i[3:0]} + {1'b0, ~a_i[3:0]} + 5'h01;
				flags_o.c = full[W];
			end
			core_pkg::ALU_AND: full = {1'b0, a_i & b_i};
			core_pkg::ALU_OR: full = {1'b0, a_i | b_i};
			core_pkg::ALU_XOR: full = {1'b0, a_i ^ b_i};
			core_pkg::ALU_NOT: full = {1'b0, ~b_i};
			core_pkg::ALU_RLC:
			begin
				full = {1'b0, b_i[W-2:0], c_i};
				flags_o.c = b_i[W-1];
			end
			core_pkg::ALU_RRC:
			begin
				full = {1'b0, c_i, b_i[W-1:1]};
				flags_o.c = b_i[0];
			end
			core_pkg::ALU_SWAP: full = {1'b0, b_i[3:0], b_i[W-1:4]};
			core_pkg::ALU_INC: full = {1'b0, b_i} + {{W{1'b0}}, 1'b1};
			core_pkg::ALU_DEC: full = {1'b0, b_i} - {{W{1'b0}}, 1'b1};
			core_pkg::ALU_CLR: full = '0;
			default: full = {1'b0, b_i};
		endcase
		y_o = full[W-1:0];
		flags_o.nc = low[4];
		flags_o.z = (y_o == core_pkg::ZERO_BYTE);
	end
endmodule // alu8
`default_nettype wire

// [core/alu_datapath.sv]
`timescale 1ns/10ps
`default_nettype none
module alu_datapath #(
	parameter int PROG_WORDS = core_pkg::PC_WORDS_LARGE
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// Program memory bus
	output logic [core_pkg::PC_W-1:0] pmem_addr_o,
	input wire logic [core_pkg::INSN_W-1:0] pmem_data_i,
	// Decoder side
	output logic [core_pkg::INSN_W-1:0] insn_o,
	output logic insn_valid_o,
	input wire core_pkg::exec_cmd_t cmd_i,
	// Data memory bus
	output logic [core_pkg::ADDR_W-1:0] dmem_raddr_o,
	input wire logic [core_pkg::DATA_W-1:0] dmem_rdata_i,
	output core_pkg::dmem_wr_t dmem_wr_o,
	// Status
	output logic [core_pkg::DATA_W-1:0] acc_o,
	output core_pkg::flags_t flags_o
);
	typedef struct packed {
		logic [core_pkg::INSN_W-1:0] insn;
		logic insn_valid;
		logic [core_pkg::DATA_W-1:0] acc;
		core_pkg::flags_t flags;
		core_pkg::dmem_wr_t wr;
		logic [core_pkg::ADDR_W-1:0] raddr;
		logic flush;
	} state_t;

	state_t s;
	state_t next_s;
	logic [core_pkg::PC_W-1:0] pc;
	logic [core_pkg::DATA_W-1:0] reg_val;
	logic [core_pkg::DATA_W-1:0] op_a;
	logic [core_pkg::DATA_W-1:0] op_b;
	logic [core_pkg::DATA_W-1:0] alu_y;
	core_pkg::flags_t alu_f;
	logic take_branch;
	logic pc_write;

	assign take_branch = cmd_i.valid && cmd_i.branch && !s.flush;
	assign pc_write = cmd_i.valid && !s.flush && cmd_i.write_reg && !cmd_i.to_acc
		&& cmd_i.reg_addr == core_pkg::PCL_ADDR;

	prog_counter #(
		.WORDS(PROG_WORDS)
	) u_pc (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.load_i(take_branch || pc_write),
		.target_i(take_branch ? cmd_i.target
			: {pc[core_pkg::PC_W-1:core_pkg::DATA_W], alu_y}),
		.pc_o(pc)
	);

	// Special registers read from inside the core
	always_comb
	begin
		if (cmd_i.reg_addr == core_pkg::STATUS_ADDR)
			reg_val = {5'h00, s.flags};
		else if (cmd_i.reg_addr == core_pkg::PCL_ADDR)
			reg_val = pc[core_pkg::DATA_W-1:0];
		else
			reg_val = dmem_rdata_i;
	end

	// Operand steering
	always_comb
	begin
		op_a = s.acc;
		if (cmd_i.one_operand)
			op_b = cmd_i.operand_is_acc ? s.acc : reg_val;
		else
			op_b = (cmd_i.src == core_pkg::SRC_LIT) ? cmd_i.literal : reg_val;
	end

	alu8 #(
		.W(core_pkg::DATA_W)
	) u_alu (
		.op_i(cmd_i.op),
		.a_i(op_a),
		.b_i(op_b),
		.c_i(s.flags.c),
		.y_o(alu_y),
		.flags_o(alu_f)
	);

	always_comb
	begin
		next_s = s;
		next_s.insn = pmem_data_i;
		next_s.insn_valid = 1'b1;
		next_s.flush = take_branch;
		next_s.wr.we = 1'b0;
		next_s.wr.addr = cmd_i.reg_addr;
		next_s.wr.data = alu_y;
		next_s.raddr = cmd_i.reg_addr;
		if (take_branch)
			next_s.insn_valid = 1'b0;
		if (cmd_i.valid && !s.flush)
		begin
			if (cmd_i.to_acc)
				next_s.acc = alu_y;
			else if (cmd_i.write_reg)
				next_s.wr.we = 1'b1;
			if (cmd_i.upd_c)
				next_s.flags.c = alu_f.c;
			if (cmd_i.upd_nc)
				next_s.flags.nc = alu_f.nc;
			if (cmd_i.upd_z)
				next_s.flags.z = alu_f.z;
			if (cmd_i.write_reg && !cmd_i.to_acc && cmd_i.reg_addr == core_pkg::STATUS_ADDR)
				next_s.flags = alu_y[2:0];
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			s.insn <= core_pkg::NOP_WORD;
			s.insn_valid <= 1'b0;
			s.acc <= core_pkg::ZERO_BYTE;
			s.flags <= '0;
			s.wr <= '0;
			s.raddr <= '0;
			s.flush <= 1'b0;
		end
		else
			s <= next_s;
	end

	// Outputs
	assign insn_o = s.insn;
	assign insn_valid_o = s.insn_valid;
	assign acc_o = s.acc;
	assign flags_o = s.flags;
	assign dmem_wr_o = s.wr;
	assign dmem_raddr_o = s.raddr;
	assign pmem_addr_o = pc;

	sequence branch_taken;
		cmd_i.valid && cmd_i.branch && !s.flush;
	endsequence
	sequence bubble;
		!insn_valid_o ##1 s.flush == 1'b0;
	endsequence

	a_branch_bubble: assert property (@(posedge clk_i) disable iff (!rstn_i)
		branch_taken |=> bubble) else $error("branch did not flush prefetch");
	a_fetch_latch: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!take_branch |=> insn_o == $past(pmem_data_i)) else $error("fetch word lost");
	a_pc_advance: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!(take_branch || pc_write) && pc != core_pkg::PC_W'(PROG_WORDS - 1)
		|=> pc == $past(pc) + 10'h001) else $error("pc did not advance");
	a_acc_update: assert property (@(posedge clk_i) disable iff (!rstn_i)
		cmd_i.valid && !s.flush && cmd_i.to_acc |=> acc_o == $past(alu_y))
		else $error("accumulator not written");
	a_single_cycle: assert property (@(posedge clk_i) disable iff (!rstn_i)
		cmd_i.valid && !s.flush && cmd_i.write_reg && !cmd_i.to_acc
		|=> dmem_wr_o.we && dmem_wr_o.data == $past(alu_y)) else $error("write late");
	a_zero_flag: assert property (@(posedge clk_i) disable iff (!rstn_i)
		cmd_i.valid && !s.flush && cmd_i.upd_z && !(cmd_i.write_reg && !cmd_i.to_acc
		&& cmd_i.reg_addr == core_pkg::STATUS_ADDR)
		|=> flags_o.z == ($past(alu_y) == core_pkg::ZERO_BYTE)) else $error("zero flag wrong");
	a_sub_borrow: assert property (@(posedge clk_i) disable iff (!rstn_i)
		cmd_i.valid && !s.flush && cmd_i.upd_c && cmd_i.op == core_pkg::ALU_SUB
		&& !(cmd_i.write_reg && !cmd_i.to_acc && cmd_i.reg_addr == core_pkg::STATUS_ADDR)
		|=> flags_o.c == ($past(op_b) >= $past(op_a))) else $error("borrow wrong");
	a_flush_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s.flush |=> $stable(acc_o) && $stable(flags_o)) else $error("flushed op executed");
	a_literal_src: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!cmd_i.one_operand && cmd_i.src == core_pkg::SRC_LIT |-> op_b == cmd_i.literal)
		else $error("literal not steered");
endmodule // alu_datapath
`default_nettype wire

// [core/prog_counter.sv]
`timescale 1ns/10ps
`default_nettype none
module prog_counter #(
	parameter int WORDS = core_pkg::PC_WORDS_LARGE
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// Control
	input wire logic load_i,
	input wire logic [core_pkg::PC_W-1:0] target_i,
	// Count
	output logic [core_pkg::PC_W-1:0] pc_o
);
	localparam logic [core_pkg::PC_W-1:0] LAST = core_pkg::PC_W'(WORDS - 1);
	logic [core_pkg::PC_W-1:0] next_pc;
	always_comb
	begin
		if (load_i)
			next_pc = target_i & LAST;
		else
			next_pc = (pc_o + 10'h001) & LAST;
	end
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			pc_o <= core_pkg::PC_RESET;
		else
			pc_o <= next_pc;
	end
	a_pc_wraps: assert property (@(posedge clk_i) disable iff (!rstn_i)
		pc_o < core_pkg::PC_W'(WORDS)) else $error("pc beyond memory");
endmodule // prog_counter
`default_nettype wire

// [include/core_pkg.sv]
// Operation
// - Fetch one 14-bit word per cycle, separate bus
// - Overlap next fetch with current execute
// - Non-branch instructions finish in one cycle
// - Branches take two cycles, flush prefetch
// - Program counter spans 512 or 1K words
// - Special registers, program counter in data space
// - Any operation on any register, any mode
// - Eight-bit ALU: add, subtract, shift, logic
// - Arithmetic is two's complement
// - Two operands: accumulator plus register or literal
// - One operand: accumulator or register
// - Eight-bit accumulator, not in data space
// - ALU updates carry, nibble carry, zero flags
// - Subtract: carries are inverted borrows
package core_pkg;
	localparam int INSN_W = 14;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 7;
	localparam int PC_W = 10;
	localparam int PC_WORDS_SMALL = 512;
	localparam int PC_WORDS_LARGE = 1024;
	localparam logic [ADDR_W-1:0] PCL_ADDR = 7'h02;
	localparam logic [ADDR_W-1:0] STATUS_ADDR = 7'h03;
	localparam logic [ADDR_W-1:0] PCLATH_ADDR = 7'h0A;
	localparam int C_BIT = 0;
	localparam int NC_BIT = 1;
	localparam int Z_BIT = 2;
	localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
	localparam logic [PC_W-1:0] PC_RESET = 10'h000;
	localparam logic [INSN_W-1:0] NOP_WORD = 14'h0000;

	typedef enum logic [3:0] {
		ALU_PASS_B, ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR,
		ALU_NOT, ALU_RLC, ALU_RRC, ALU_SWAP, ALU_INC, ALU_DEC, ALU_CLR
	} alu_op_t;

	typedef enum logic [1:0] {
		SRC_REG, SRC_LIT
	} src_sel_t;

	// Decoded operation from the instruction decoder
	typedef struct packed {
		logic valid;
		alu_op_t op;
		logic one_operand;
		logic operand_is_acc;
		src_sel_t src;
		logic [DATA_W-1:0] literal;
		logic [ADDR_W-1:0] reg_addr;
		logic to_acc;
		logic write_reg;
		logic upd_c;
		logic upd_nc;
		logic upd_z;
		logic branch;
		logic [PC_W-1:0] target;
	} exec_cmd_t;

	// ALU flags
	typedef struct packed {
		logic z;
		logic nc;
		logic c;
	} flags_t;

	// Data memory write request
	typedef struct packed {
		logic we;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} dmem_wr_t;
endpackage
